// [core/sbdio_consts.svh]
`ifndef SBDIO_CONSTS_SVH
`define SBDIO_CONSTS_SVH

// ****************************************************************
// Register map of the script engine.
// ****************************************************************
`define SBDIO_ADDR_W 8
`define SBDIO_OFF_CMD 8'h00
`define SBDIO_OFF_GO 8'h04
`define SBDIO_OFF_STATUS 8'h08
`define SBDIO_OFF_CLEAR 8'h0C
`define SBDIO_OFF_RDIDX 8'h10
`define SBDIO_OFF_RDDATA 8'h14

// ****************************************************************
// Command word layout: opcode, port, line, value.
// ****************************************************************
`define SBDIO_OP_LSB 0
`define SBDIO_OP_MSB 2
`define SBDIO_PORT_LSB 4
`define SBDIO_PORT_MSB 7
`define SBDIO_LINE_LSB 8
`define SBDIO_LINE_MSB 10
`define SBDIO_VAL_LSB 16
`define SBDIO_VAL_MSB 23

// ****************************************************************
// Status bits and reset values.
// ****************************************************************
`define SBDIO_ST_BUSY 0
`define SBDIO_ST_ERR 1
`define SBDIO_DIR_RST 8'h00
`define SBDIO_OUT_RST 8'h00

`endif

// [core/sbdio_pkg.sv]
// ****************************************************************
// Types shared by the script engine.
// ****************************************************************
package sbdio_pkg;
    // Script opcodes as stored in the command word.
    typedef enum logic [2:0]
    {
        SBDIO_OP_CFG_LINE = 3'h0,
        SBDIO_OP_CFG_PORT = 3'h1,
        SBDIO_OP_RD_LINE = 3'h2,
        SBDIO_OP_RD_PORT = 3'h3,
        SBDIO_OP_WR_LINE = 3'h4,
        SBDIO_OP_WR_PORT = 3'h5
    } sbdio_op_e;

    // Engine states, one-hot.
    typedef enum logic [2:0]
    {
        SBDIO_IDLE = 3'b001,
        SBDIO_FETCH = 3'b010,
        SBDIO_EXEC = 3'b100
    } sbdio_state_e;
endpackage

// [core/sbdio_port.sv]
`include "sbdio_consts.svh"

// ****************************************************************
// One byte-wide port: direction, output latch and input sync.
// ****************************************************************
module sbdio_port
    import sbdio_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic sel, // This port is addressed by the command.
    input wire logic cfg_line, // Configure one line.
    input wire logic cfg_port, // Configure all lines.
    input wire logic wr_line, // Write one line.
    input wire logic wr_port, // Write whole port.
    input wire logic [2:0] line, // Line number.
    input wire logic [7:0] value, // Bitmap or write value.
    input wire logic [7:0] pin_i, // Pin levels from outside.
    output logic [7:0] pin_o, // Pin drive values.
    output logic [7:0] pin_oe_n, // Pin drive enables, low drives.
    output logic [7:0] level // Synchronised pin levels.
);
    import sbdio_pkg::*;

    logic [7:0] dir_reg; // One means output.
    logic [7:0] dir_next; // Next direction.
    logic [7:0] out_reg; // Output latch.
    logic [7:0] out_next; // Next output latch.
    logic [7:0] s1_reg; // First synchroniser stage.
    logic [7:0] s2_reg; // Second synchroniser stage.
    logic [7:0] lmask; // One-hot line mask.

    // Direction and output latch updates.
    always_comb
    begin
        lmask = 8'h01 << line;
        dir_next = dir_reg;
        out_next = out_reg;
        if (sel && cfg_line)
        begin
            // Only the addressed bit moves; the other seven keep their state.
            dir_next = (dir_reg & ~lmask) | (value[0] ? lmask : 8'h00);
        end
        else if (sel && cfg_port)
        begin
            dir_next = value;
        end
        else if (sel && wr_line)
        begin
            out_next = (out_reg & ~lmask) | (value[0] ? lmask : 8'h00);
        end
        else if (sel && wr_port)
        begin
            out_next = value;
        end
    end

    // Registers; the latch is kept even for inputs so a later turn drives it.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_reg <= `SBDIO_DIR_RST;
            out_reg <= `SBDIO_OUT_RST;
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
            pin_o <= 8'h00;
            pin_oe_n <= 8'hFF;
        end
        else
        begin
            dir_reg <= dir_next;
            out_reg <= out_next;
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            pin_o <= out_next;
            pin_oe_n <= ~dir_next;
        end
    end

    assign level = s2_reg;

    // Input lines are never driven.
    a_input_undriven: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (~dir_reg == pin_oe_n))
        else $error("input line driven");

    // A line configure sets the addressed direction bit and leaves the other seven alone.
    a_line_cfg_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel && cfg_line)
        |=> (((dir_reg & ~$past(lmask)) == ($past(dir_reg) & ~$past(lmask)))
        && (dir_reg[$past(line)] == $past(value[0]))))
        else $error("line configure wrong");

    // A port configure loads the whole bitmap in a single step.
    a_port_cfg_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel && cfg_port && !cfg_line) |=> (dir_reg == $past(value)))
        else $error("port configure not applied");
endmodule

// [core/sbdio_top.sv]
// The register addresses and the strobed register port are this design's own decisions.
`include "sbdio_consts.svh"

module sbdio_top
    import sbdio_pkg::*;
#(
    parameter int NPORTS = 1, // Number of byte-wide ports.
    parameter int DEPTH = 16, // Script command slots.
    parameter int RDEPTH = 16 // Read result slots.
)
(
    input wire logic sys_clk, // System clock, 50 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [7:0] addr, // Register byte address.
    input wire logic [31:0] wdata, // Write data.
    input wire logic wr_en, // Write strobe.
    input wire logic rd_en, // Read strobe.
    output logic [31:0] rdata, // Read data, one cycle after strobe.
    input wire logic [NPORTS*8-1:0] dio_i, // Pin levels.
    output logic [NPORTS*8-1:0] dio_o, // Pin drive values.
    output logic [NPORTS*8-1:0] dio_oe_n, // Pin enables, low drives.
    output logic busy // Script running.
);
    import sbdio_pkg::*;

    // ****************************************************************
    // Script storage and engine state.
    // ****************************************************************
    localparam int AW = $clog2(DEPTH); // Script address width.
    localparam int RW = $clog2(RDEPTH); // Result address width.

    logic [23:0] script_mem [DEPTH]; // Command words in listed order.
    logic [7:0] res_mem [RDEPTH]; // Read results by index.
    sbdio_state_e st_reg; // Engine state.
    sbdio_state_e st_next; // Next state.
    logic [AW:0] wp_reg; // Commands loaded.
    logic [AW:0] wp_next; // Next load count.
    logic [AW:0] pc_reg; // Index of the command to fetch next.
    logic [AW:0] pc_next; // Next command.
    logic [RW:0] ri_reg; // Next read index.
    logic [RW:0] ri_next; // Next read index value.
    logic [23:0] cmd_reg; // Fetched command.
    logic [23:0] cmd_next; // Next fetched command.
    logic err_reg; // Overflow or bad port seen.
    logic err_next; // Next error flag.
    logic [RW-1:0] sel_reg; // Result index chosen by software.
    logic [RW-1:0] sel_next; // Next chosen index.
    logic [31:0] rdata_next; // Next read data.
    logic res_we; // Store a read result.
    logic [7:0] res_val; // Value to store.
    logic [NPORTS*8-1:0] lvl; // Synchronised pin levels.
    logic [7:0] plvl; // Levels of the addressed port.
    logic [3:0] cport; // Port field of command.
    logic [2:0] cline; // Line field of command.
    logic [2:0] cop; // Opcode field.
    logic exec; // Command applied this cycle.
    logic [7:0] rdval; // Stored result at chosen index.

    assign cop = cmd_reg[`SBDIO_OP_MSB:`SBDIO_OP_LSB];
    assign cport = cmd_reg[`SBDIO_PORT_MSB:`SBDIO_PORT_LSB];
    assign cline = cmd_reg[`SBDIO_LINE_MSB:`SBDIO_LINE_LSB];
    assign exec = (st_reg == SBDIO_EXEC);
    assign rdval = res_mem[sel_reg];

    // ****************************************************************
    // Port instances, each decoding its own number.
    // ****************************************************************
    for (genvar p = 0; p < NPORTS; p++)
    begin : g_port
        sbdio_port u_port (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .sel(exec && (cport == 4'(p))),
            .cfg_line(cop == SBDIO_OP_CFG_LINE),
            .cfg_port(cop == SBDIO_OP_CFG_PORT),
            .wr_line(cop == SBDIO_OP_WR_LINE),
            .wr_port(cop == SBDIO_OP_WR_PORT),
            .line(cline),
            .value(cmd_reg[`SBDIO_VAL_MSB:`SBDIO_VAL_LSB]),
            .pin_i(dio_i[p*8 +: 8]),
            .pin_o(dio_o[p*8 +: 8]),
            .pin_oe_n(dio_oe_n[p*8 +: 8]),
            .level(lvl[p*8 +: 8])
        );
    end

    // Level of the addressed port; an unknown port reads as zero.
    always_comb
    begin
        plvl = 8'h00;
        for (int p = 0; p < NPORTS; p++)
        begin
            if (cport == 4'(p))
            begin
                plvl = lvl[p*8 +: 8];
            end
        end
    end

    // ****************************************************************
    // Engine and register bus, next values.
    // ****************************************************************
    always_comb
    begin
        st_next = st_reg;
        wp_next = wp_reg;
        pc_next = pc_reg;
        ri_next = ri_reg;
        cmd_next = cmd_reg;
        err_next = err_reg;
        sel_next = sel_reg;
        res_we = 1'b0;
        res_val = 8'h00;
        case (st_reg)
            SBDIO_IDLE:
            begin
                if (wr_en && addr == `SBDIO_OFF_GO && wp_reg != '0)
                begin
                    pc_next = '0;
                    ri_next = '0;
                    st_next = SBDIO_FETCH;
                end
            end
            SBDIO_FETCH:
            begin
                // One command at a time keeps later commands behind a direction change.
                cmd_next = script_mem[pc_reg[AW-1:0]];
                pc_next = pc_reg + 1'b1;
                st_next = SBDIO_EXEC;
            end
            SBDIO_EXEC:
            begin
                if (cport >= 4'(NPORTS))
                begin
                    err_next = 1'b1;
                end
                if (cop == SBDIO_OP_RD_LINE || cop == SBDIO_OP_RD_PORT)
                begin
                    if (ri_reg < (RW+1)'(RDEPTH))
                    begin
                        res_we = 1'b1;
                    end
                    else
                    begin
                        err_next = 1'b1;
                    end
                    ri_next = ri_reg + 1'b1;
                    res_val = (cop == SBDIO_OP_RD_LINE) ? {7'h00, plvl[cline]} : plvl;
                end
                st_next = (pc_reg == wp_reg) ? SBDIO_IDLE : SBDIO_FETCH;
            end
            default:
            begin
                st_next = SBDIO_IDLE;
            end
        endcase
        if (st_reg == SBDIO_IDLE && wr_en)
        begin
            if (addr == `SBDIO_OFF_CMD)
            begin
                if (wp_reg < (AW+1)'(DEPTH))
                begin
                    wp_next = wp_reg + 1'b1;
                end
                else
                begin
                    err_next = 1'b1;
                end
            end
            else if (addr == `SBDIO_OFF_CLEAR)
            begin
                wp_next = '0;
                err_next = 1'b0;
            end
        end
        if (wr_en && addr == `SBDIO_OFF_RDIDX)
        begin
            sel_next = wdata[RW-1:0];
        end
        rdata_next = 32'h0;
        if (rd_en)
        begin
            if (addr == `SBDIO_OFF_STATUS)
            begin
                rdata_next = {30'h0, err_reg, st_reg != SBDIO_IDLE};
            end
            else if (addr == `SBDIO_OFF_RDIDX)
            begin
                rdata_next = 32'(ri_reg);
            end
            else if (addr == `SBDIO_OFF_RDDATA)
            begin
                rdata_next = {24'h0, rdval};
            end
        end
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= SBDIO_IDLE;
            wp_reg <= '0;
            pc_reg <= '0;
            ri_reg <= '0;
            cmd_reg <= 24'h0;
            err_reg <= 1'b0;
            sel_reg <= '0;
            rdata <= 32'h0;
            busy <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            wp_reg <= wp_next;
            pc_reg <= pc_next;
            ri_reg <= ri_next;
            cmd_reg <= cmd_next;
            err_reg <= err_next;
            sel_reg <= sel_next;
            rdata <= rdata_next;
            busy <= (st_next != SBDIO_IDLE);
        end
    end

    // Memories carry no reset; they are written only under control.
    always_ff @(posedge sys_clk)
    begin
        if (st_reg == SBDIO_IDLE && wr_en && addr == `SBDIO_OFF_CMD && wp_reg < (AW+1)'(DEPTH))
        begin
            script_mem[wp_reg[AW-1:0]] <= wdata[23:0];
        end
        if (res_we)
        begin
            res_mem[ri_reg[RW-1:0]] <= res_val;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence s_fetch_exec;
        (st_reg == SBDIO_FETCH) ##1 (st_reg == SBDIO_EXEC);
    endsequence

    a_order_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_reg == SBDIO_FETCH) |-> s_fetch_exec)
        else $error("fetch not followed by execute");

    a_read_index: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (exec && (cop == SBDIO_OP_RD_LINE || cop == SBDIO_OP_RD_PORT))
        |=> (ri_reg == $past(ri_reg) + 1'b1))
        else $error("read index not advanced");

    a_line_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (res_we && cop == SBDIO_OP_RD_LINE) |-> (res_val == {7'h00, plvl[cline]}))
        else $error("line result wrong");
endmodule

// [tb/sbdio_pins.sv]
// ****************************************************************
// Outside world wired to the digital lines.
// ****************************************************************
module sbdio_pins
#(
    parameter int NPORTS = 1 // Number of byte-wide ports.
)
(
    input wire logic [NPORTS*8-1:0] dio_o, // Drive values from the block.
    input wire logic [NPORTS*8-1:0] dio_oe_n, // Drive enables, low drives.
    input wire logic [NPORTS*8-1:0] ext_lvl, // Levels the outside tries to impose.
    output logic [NPORTS*8-1:0] dio_i // Resolved wire levels.
);
    timeunit 1ns;
    timeprecision 1ps;

    // The outside sources are weak, so a driven line shows the block's value.
    // A released line shows the outside level and never a stale drive value.
    always_comb
    begin
        dio_i = (dio_o & ~dio_oe_n) | (ext_lvl & dio_oe_n);
    end
endmodule

// [tb/tb_sbdio_top.sv]
`include "sbdio_consts.svh"

// ****************************************************************
// Self-checking bench for the scripted port engine.
// ****************************************************************
module tb_sbdio_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sbdio_pkg::*;

    localparam int NP = 2; // Two ports, so port selection can be seen.
    logic sys_clk, rst_n, wr_en, rd_en, busy; // Clock, reset, strobes, busy.
    logic [7:0] addr; // Register address.
    logic [31:0] wdata, rdata, got; // Bus data and a read result.
    logic [NP*8-1:0] dio_i, dio_o, dio_oe_n, ext_lvl; // Pin wiring.
    int n_fail, tests_run; // Mismatch and comparison counters.
    logic [7:0] exp_rd [4]; // Expected read results by index.

    sbdio_top #(.NPORTS(NP), .DEPTH(16), .RDEPTH(16)) dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .dio_i(dio_i), .dio_o(dio_o), .dio_oe_n(dio_oe_n), .busy(busy));

    sbdio_pins #(.NPORTS(NP)) pins (.dio_o(dio_o), .dio_oe_n(dio_oe_n),
        .ext_lvl(ext_lvl), .dio_i(dio_i));

    // The clock toggles every half period of 10 ns.
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // Shared bus and checking tasks.
    // ****************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
            n_fail++;
        end
    endtask

    // One write cycle; a full edge passes before the next strobe.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    // One read cycle; data is taken in the single cycle it stands.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // Appends one command word to the script.
    task automatic cmd(input sbdio_op_e op, input logic [3:0] p, input logic [2:0] l,
        input logic [7:0] v);
        wr(`SBDIO_OFF_CMD, {8'h00, v, 5'h00, l, p, 1'b0, op});
    endtask

    // Runs the script and waits, bounded, for the engine to go idle.
    task automatic run();
        int i;
        wr(`SBDIO_OFF_GO, 32'h0000_0001);
        // Busy is looked at just after each edge, never in the edge's own time step.
        #1;
        for (i = 0; i < 200 && busy !== 1'b0; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 200)
        begin
            $display("ERROR at %0t: got %h expected %h", $time, busy, 1'b0);
            n_fail++;
            test_done();
        end
        // Pins settle and cross the two sync flops before anyone looks.
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_cfg();
        wr(`SBDIO_OFF_CLEAR, 32'h0);
        cmd(SBDIO_OP_CFG_PORT, 4'h0, 3'h0, 8'hA5);
        run();
        chk(dio_oe_n, 16'hFF5A);
        rd(`SBDIO_OFF_STATUS, got);
        chk(got, 32'h0);
        // Two line commands: one line turns out, another turns in.
        wr(`SBDIO_OFF_CLEAR, 32'h0);
        cmd(SBDIO_OP_CFG_LINE, 4'h0, 3'h1, 8'h01);
        cmd(SBDIO_OP_CFG_LINE, 4'h0, 3'h0, 8'h00);
        run();
        chk(dio_oe_n, 16'hFF59);
        $display("test configure done");
    endtask

    task automatic t_write();
        wr(`SBDIO_OFF_CLEAR, 32'h0);
        cmd(SBDIO_OP_WR_PORT, 4'h0, 3'h0, 8'hFF);
        run();
        chk(dio_i[7:0], 8'hA6);
        chk(dio_oe_n, 16'hFF59);
        chk(dio_o, 16'h00FF);
        // One output line goes low; input lines keep showing the outside level.
        wr(`SBDIO_OFF_CLEAR, 32'h0);
        cmd(SBDIO_OP_WR_LINE, 4'h0, 3'h1, 8'h00);
        run();
        chk(dio_o, 16'h00FD);
        chk(dio_i[7:0], 8'hA4);
        $display("test port write done");
    endtask

    task automatic t_reads();
        int i;
        exp_rd = '{8'h01, 8'h00, 8'h3C, 8'hA4};
        wr(`SBDIO_OFF_CLEAR, 32'h0);
        cmd(SBDIO_OP_RD_LINE, 4'h1, 3'h2, 8'h00);
        cmd(SBDIO_OP_RD_LINE, 4'h1, 3'h0, 8'h00);
        cmd(SBDIO_OP_RD_PORT, 4'h1, 3'h0, 8'h00);
        cmd(SBDIO_OP_RD_PORT, 4'h0, 3'h0, 8'h00);
        run();
        rd(`SBDIO_OFF_RDIDX, got);
        chk(got, 32'h4);
        for (i = 0; i < 4; i++)
        begin
            wr(`SBDIO_OFF_RDIDX, i);
            rd(`SBDIO_OFF_RDDATA, got);
            chk(got, {24'h0, exp_rd[i]});
        end
        $display("test reads done");
    endtask

    task automatic t_order();
        wr(`SBDIO_OFF_CLEAR, 32'h0);
        cmd(SBDIO_OP_CFG_PORT, 4'h1, 3'h0, 8'h0F);
        cmd(SBDIO_OP_CFG_LINE, 4'h1, 3'h7, 8'h01);
        run();
        chk(dio_oe_n, 16'h7059);
        $display("test order done");
    endtask

    // A port beyond the fitted ones moves no pin and flags an error.
    task automatic t_error();
        wr(`SBDIO_OFF_CLEAR, 32'h0);
        cmd(SBDIO_OP_CFG_PORT, 4'h2, 3'h0, 8'hFF);
        run();
        chk(dio_oe_n, 16'h7059);
        rd(`SBDIO_OFF_STATUS, got);
        chk(got, 32'h2);
        rd(8'hFC, got);
        chk(got, 32'h0);
        $display("test error done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        n_fail = 0;
        tests_run = 0;
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        ext_lvl = 16'h3C00; // Port one shows a fixed pattern, port zero low.
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk(dio_oe_n, 16'hFFFF);
        chk(dio_o, 16'h0000);
        chk(busy, 1'b0);
        $display("test reset done");
        t_cfg();
        t_write();
        t_reads();
        t_order();
        t_error();
        test_done();
    end
endmodule
